//--- hw/smbreg_pkg.sv
package smbreg_pkg;

  // ****************************************
  // register indices, byte address is index * 4
  // ****************************************
  localparam logic [2:0] IDX_STATUS = 3'h1;
  localparam logic [2:0] IDX_MASK = 3'h2;
  localparam logic [2:0] IDX_DATA = 3'h3;
  localparam logic [2:0] IDX_PRIM = 3'h4;
  localparam logic [2:0] IDX_SEC = 3'h5;
  localparam logic [2:0] IDX_OVR = 3'h6;

  // ****************************************
  // field positions of the line override register
  // ****************************************
  localparam int OVR_CLK_LVL = 7;
  localparam int OVR_DATA_LVL = 6;
  localparam int OVR_QUIET = 5;
  localparam int OVR_CLK_PULL = 4;
  localparam int OVR_DATA_PULL = 3;
  localparam int OVR_ABORT = 2;
  localparam int OVR_BUSY = 1;
  localparam int OVR_DETECT = 0;

  // ****************************************
  // field positions shared by status flags and mask
  // ****************************************
  localparam int FLG_CLK_HELD = 6;
  localparam int FLG_TIMEOUT = 5;
  localparam int FLG_MST_DONE = 4;
  localparam int FLG_ACK = 3;
  localparam int FLG_STOP = 2;
  localparam int FLG_REP_START = 1;
  localparam int FLG_START = 0;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [6:0] MASK_RST = 7'h00;
  localparam logic [6:0] FLAGS_RST = 7'h04;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic FORCE_RST = 1'b0;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int BUS_QUIET_NS = 50000;
  localparam int BUS_QUIET_CYC = (BUS_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // carriers
  // ****************************************
  // event pulses from the bus engine, ordered as the flag bits D6..D0
  typedef struct packed {
    logic clk_held;
    logic timeout;
    logic master_done;
    logic ack;
    logic stop;
    logic rep_start;
    logic start;
  } smbreg_evt_s;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [6:0] mask;
    logic [6:0] flags;
    logic [7:0] data;
    logic [7:0] prim;
    logic [7:0] sec;
    logic clk_pull;
    logic data_pull;
    logic abort;
    logic irq;
    logic clk_oe_n;
    logic data_oe_n;
    logic match_one;
    logic match_two;
  } smbreg_state_s;

endpackage

//--- hw/smbreg_sync.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// two flop synchroniser for pin levels
// ****************************************
module smbreg_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } smbreg_sync_s;

  smbreg_sync_s st;
  smbreg_sync_s next_st;

  always_comb begin
    next_st.meta = d_i;
    next_st.stable = st.meta;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q_o = st.stable;

endmodule

`default_nettype wire

//--- hw/smbreg_idle.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// bus quiet detector: both lines high for CYC cycles
// ****************************************
module smbreg_idle #(
  parameter int CYC = smbreg_pkg::BUS_QUIET_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clk_line_i,
  input wire logic data_line_i,
  output logic quiet_o
);
  import smbreg_pkg::*;

  localparam int CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] CNT_MAX = CW'(CYC);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic quiet;
  } smbreg_idle_s;

  smbreg_idle_s st;
  smbreg_idle_s next_st;

  always_comb begin
    next_st = st;
    // any low level restarts the wait, the count saturates
    if (!(clk_line_i && data_line_i)) begin
      next_st.cnt = '0;
    end else if (st.cnt != CNT_MAX) begin
      next_st.cnt = st.cnt + CW'(1);
    end
    next_st.quiet = (next_st.cnt == CNT_MAX);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign quiet_o = st.quiet;

endmodule

`default_nettype wire

//--- hw/smbreg_top.sv
`timescale 1ns/10ps
`default_nettype none

module smbreg_top #(
  parameter int ADR_W = 8,
  parameter int QUIET_CYC = smbreg_pkg::BUS_QUIET_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // bus engine side, same clock
  input wire smbreg_pkg::smbreg_evt_s evt_i,
  input wire logic master_mode_i,
  input wire logic master_busy_i,
  input wire logic rx_load_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic addr_valid_i,
  input wire logic [7:0] rx_addr_i,
  input wire logic eng_clk_low_i,
  input wire logic eng_data_low_i,
  output logic [7:0] smb_data_buffer_o,
  output logic bus_engine_abort_o,
  output logic addr_match_one_o,
  output logic addr_match_two_o,
  output logic bus_irq_line_o,
  // pins
  input wire logic clk_line_i,
  input wire logic data_line_i,
  input wire logic detect_i,
  output logic clk_line_o,
  output logic clk_line_oe_n_o,
  output logic data_line_o,
  output logic data_line_oe_n_o
);
  import smbreg_pkg::*;

  // ****************************************
  // pin synchronisers and quiet detector
  // ****************************************
  logic [2:0] pins_sync;
  logic clk_line_level;
  logic data_line_level;
  logic detect_level;
  logic bus_quiet;

  smbreg_sync #(
    .W(3)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({clk_line_i, data_line_i, detect_i}),
    .q_o(pins_sync)
  );

  assign clk_line_level = pins_sync[2];
  assign data_line_level = pins_sync[1];
  assign detect_level = pins_sync[0];

  smbreg_idle #(
    .CYC(QUIET_CYC)
  ) u_idle (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clk_line_i(clk_line_level),
    .data_line_i(data_line_level),
    .quiet_o(bus_quiet)
  );

  // ****************************************
  // state
  // ****************************************
  smbreg_state_s st;
  smbreg_state_s next_st;

  logic hit;
  logic done;
  logic mapped;
  logic [2:0] idx;
  logic wr_lane;
  logic [7:0] rd_byte;
  logic [6:0] gate;

  always_comb begin
    next_st = st;
    hit = cyc_i && stb_i;
    // access completes on the edge where ack is seen high
    done = hit && st.ack;
    idx = adr_i[4:2];
    mapped = (adr_i[1:0] == 2'h0) && (adr_i[ADR_W-1:5] == '0);
    wr_lane = done && we_i && sel_i[0] && mapped;
    rd_byte = 8'h00;
    gate = 7'h00;

    // ****************************************
    // wishbone answer, one wait state
    // ****************************************
    next_st.ack = hit && !st.ack;
    next_st.abort = 1'b0;

    if (mapped) begin
      unique case (idx)
        IDX_STATUS: begin
          rd_byte = {1'b0, st.flags};
        end
        IDX_MASK: begin
          rd_byte = {1'b0, st.mask};
        end
        IDX_DATA: begin
          rd_byte = st.data;
        end
        IDX_OVR: begin
          rd_byte[OVR_CLK_LVL] = clk_line_level;
          rd_byte[OVR_DATA_LVL] = data_line_level;
          rd_byte[OVR_QUIET] = bus_quiet;
          rd_byte[OVR_CLK_PULL] = st.clk_pull;
          rd_byte[OVR_DATA_PULL] = st.data_pull;
          rd_byte[OVR_BUSY] = master_busy_i;
          rd_byte[OVR_DETECT] = detect_level;
        end
        default: begin
          // address latches are write-only and read as zero
          rd_byte = 8'h00;
        end
      endcase
    end
    next_st.rdata = {24'h000000, rd_byte};

    // ****************************************
    // status flags
    // ****************************************
    // the first four clear on any access of the data buffer
    if (done && mapped && idx == IDX_DATA) begin
      next_st.flags[FLG_CLK_HELD] = 1'b0;
      next_st.flags[FLG_TIMEOUT] = 1'b0;
      next_st.flags[FLG_MST_DONE] = 1'b0;
      next_st.flags[FLG_ACK] = 1'b0;
    end
    if (wr_lane && idx == IDX_STATUS) begin
      next_st.flags[2:0] = st.flags[2:0] & ~dat_i[2:0];
    end
    // set wins over a clear in the same cycle
    next_st.flags = next_st.flags | evt_i;

    // ****************************************
    // register writes
    // ****************************************
    if (wr_lane) begin
      unique case (idx)
        IDX_MASK: begin
          next_st.mask = dat_i[6:0];
        end
        IDX_DATA: begin
          next_st.data = dat_i[7:0];
        end
        IDX_PRIM: begin
          next_st.prim = dat_i[7:0];
        end
        IDX_SEC: begin
          next_st.sec = dat_i[7:0];
        end
        IDX_OVR: begin
          next_st.clk_pull = dat_i[OVR_CLK_PULL];
          next_st.data_pull = dat_i[OVR_DATA_PULL];
          next_st.abort = dat_i[OVR_ABORT];
        end
        default: begin
          next_st.abort = 1'b0;
        end
      endcase
    end
    // a received byte overrides a software write in the same cycle
    if (rx_load_i) begin
      next_st.data = rx_byte_i;
    end

    // ****************************************
    // interrupt gating
    // ****************************************
    gate[FLG_CLK_HELD] = st.mask[FLG_CLK_HELD];
    gate[FLG_TIMEOUT] = st.mask[FLG_TIMEOUT];
    gate[FLG_MST_DONE] = st.mask[FLG_MST_DONE] && master_mode_i;
    gate[FLG_ACK] = st.mask[FLG_ACK];
    gate[FLG_STOP] = st.mask[FLG_STOP] && !master_mode_i;
    gate[FLG_REP_START] = st.mask[FLG_REP_START] && !master_mode_i;
    gate[FLG_START] = st.mask[FLG_START] && !master_mode_i;
    next_st.irq = |(next_st.flags & gate);

    // ****************************************
    // line drivers and address comparator
    // ****************************************
    // the force bits pull low whatever the engine wants
    next_st.clk_oe_n = !(next_st.clk_pull || eng_clk_low_i);
    next_st.data_oe_n = !(next_st.data_pull || eng_data_low_i);
    // bit 0 of each latch never enters the compare
    next_st.match_one = addr_valid_i && (rx_addr_i[7:1] == st.prim[7:1]);
    next_st.match_two = addr_valid_i && (rx_addr_i[7:1] == st.sec[7:1]);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.mask <= MASK_RST;
      st.flags <= FLAGS_RST;
      st.data <= DATA_RST;
      st.prim <= ADDR_RST;
      st.sec <= ADDR_RST;
      st.clk_pull <= FORCE_RST;
      st.data_pull <= FORCE_RST;
      st.clk_oe_n <= 1'b1;
      st.data_oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs, all from flops except the two line drive levels, which are tied low
  // ****************************************
  assign ack_o = st.ack;
  assign dat_o = st.rdata;
  assign smb_data_buffer_o = st.data;
  assign bus_engine_abort_o = st.abort;
  assign addr_match_one_o = st.match_one;
  assign addr_match_two_o = st.match_two;
  assign bus_irq_line_o = st.irq;
  assign clk_line_o = 1'b0;
  assign clk_line_oe_n_o = st.clk_oe_n;
  assign data_line_o = 1'b0;
  assign data_line_oe_n_o = st.data_oe_n;

endmodule

`default_nettype wire

//--- verification/smbreg_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// port checker
// ****************************************
module smbreg_chk #(
  parameter int ADR_W = 8,
  parameter int QUIET_CYC = smbreg_pkg::BUS_QUIET_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic ack_o,
  input wire logic rx_load_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic addr_valid_i,
  input wire logic [7:0] smb_data_buffer_o,
  input wire logic bus_engine_abort_o,
  input wire logic addr_match_one_o,
  input wire logic addr_match_two_o,
  input wire logic bus_irq_line_o,
  input wire logic clk_line_oe_n_o,
  input wire logic data_line_oe_n_o
);
  import smbreg_pkg::*;
  logic ovr_wr;
  // the write lands at the ack edge, so the antecedent is the acked cycle
  assign ovr_wr = cyc_i && stb_i && we_i && ack_o && sel_i[0] && adr_i == ADR_W'(8'h18);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_wait; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack_wait: assert property (p_ack_wait) else $error("ack missing after request");
  property p_ack_one; ack_o |=> !ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
  property p_clk_pull; ovr_wr && dat_i[4] |-> ##1 !clk_line_oe_n_o; endproperty
  a_clk_pull: assert property (p_clk_pull) else $error("clock line not pulled");
  property p_data_pull; ovr_wr && dat_i[3] |-> ##1 !data_line_oe_n_o; endproperty
  a_data_pull: assert property (p_data_pull) else $error("data line not pulled");
  property p_abort; ovr_wr && dat_i[2] |-> ##1 bus_engine_abort_o; endproperty
  a_abort: assert property (p_abort) else $error("abort pulse missing");
  property p_irq_rst; $fell(rst_i) |-> !bus_irq_line_o; endproperty
  a_irq_rst: assert property (p_irq_rst) else $error("irq high after reset");
  property p_match; !addr_valid_i |=> !addr_match_one_o && !addr_match_two_o; endproperty
  a_match: assert property (p_match) else $error("match without address");
  property p_rx; rx_load_i |=> smb_data_buffer_o == $past(rx_byte_i); endproperty
  a_rx: assert property (p_rx) else $error("received byte not loaded");
  c_ovr: cover property (ovr_wr && dat_i[2]);
  c_irq: cover property ($rose(bus_irq_line_o));
  c_match: cover property (addr_match_one_o);
endmodule
bind smbreg_top smbreg_chk #(.ADR_W(ADR_W), .QUIET_CYC(QUIET_CYC)) i_smbreg_chk (
  .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .ack_o, .rx_load_i,
  .rx_byte_i, .addr_valid_i, .smb_data_buffer_o, .bus_engine_abort_o, .addr_match_one_o,
  .addr_match_two_o, .bus_irq_line_o, .clk_line_oe_n_o, .data_line_oe_n_o);
`default_nettype wire

//--- verification/smbreg_host.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// far side: open-drain lines with pull-ups
// ****************************************
module smbreg_host (
  input wire logic clk_i,
  input wire logic clk_oe_n_i,
  input wire logic data_oe_n_i,
  input wire logic clk_drv_i,
  input wire logic data_drv_i,
  input wire logic clk_low_i,
  input wire logic data_low_i,
  output logic clk_line_o,
  output logic data_line_o
);
  logic clk_hold;
  logic data_hold;
  always_ff @(posedge clk_i) begin
    clk_hold <= clk_low_i;
    data_hold <= data_low_i;
  end
  // wired-and: a released line goes to the pull-up level, never the last value
  // an enabled driver that shows a high level leaves the line at the pull-up
  assign clk_line_o = (clk_oe_n_i || clk_drv_i) && !clk_hold;
  assign data_line_o = (data_oe_n_i || data_drv_i) && !data_hold;
endmodule
`default_nettype wire

//--- verification/test_smbreg_top.sv
`timescale 1ns/10ps
`default_nettype none
module test_smbreg_top;
  import smbreg_pkg::*;
  localparam int QC = 10;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0] adr = 8'h00, rx_byte = 8'h00, rx_addr = 8'h00, buf_o;
  logic [31:0] dat = 32'h0, rdat;
  smbreg_evt_s evt = smbreg_evt_s'(7'h00);
  logic mmode = 1'b0, busy = 1'b0, rx_load = 1'b0, av = 1'b0, det = 1'b0;
  logic hcl = 1'b0, hdl = 1'b0, cl, dl, cl_oe_n, dl_oe_n, abort, m1, m2, irq;
  logic ecl = 1'b0, edl = 1'b0, cdrv, ddrv;
  int mismatches = 0, total_checks = 0, aborts = 0;
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) if (abort === 1'b1) aborts++;
  smbreg_top #(.QUIET_CYC(QC)) i_smbreg_top (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(dat), .dat_o(rdat), .ack_o(ack),
    .evt_i(evt), .master_mode_i(mmode), .master_busy_i(busy), .rx_load_i(rx_load),
    .rx_byte_i(rx_byte), .addr_valid_i(av), .rx_addr_i(rx_addr), .eng_clk_low_i(ecl),
    .eng_data_low_i(edl), .smb_data_buffer_o(buf_o), .bus_engine_abort_o(abort),
    .addr_match_one_o(m1), .addr_match_two_o(m2), .bus_irq_line_o(irq),
    .clk_line_i(cl), .data_line_i(dl), .detect_i(det), .clk_line_o(cdrv),
    .clk_line_oe_n_o(cl_oe_n), .data_line_o(ddrv), .data_line_oe_n_o(dl_oe_n));
  smbreg_host i_smbreg_host (.clk_i, .clk_oe_n_i(cl_oe_n), .data_oe_n_i(dl_oe_n),
    .clk_drv_i(cdrv), .data_drv_i(ddrv), .clk_low_i(hcl), .data_low_i(hdl),
    .clk_line_o(cl), .data_line_o(dl));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, 24'h000000, d};
    // values read right after the edge are those sampled at it
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat[7:0];
    chk("ack", 8'h01, {7'h00, ack});
    {cyc, stb} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(nm, e, q);
  endtask
  task automatic pulse(input int i);
    @(posedge clk_i);
    evt <= smbreg_evt_s'(7'h01 << i);
    @(posedge clk_i);
    evt <= smbreg_evt_s'(7'h00);
    repeat (2) @(posedge clk_i);
  endtask
  task automatic match(input logic [7:0] a, input logic [1:0] e);
    @(posedge clk_i);
    {av, rx_addr} <= {1'b1, a};
    @(posedge clk_i);
    av <= 1'b0;
    @(posedge clk_i);
    chk("match", {6'h00, e}, {6'h00, m1, m2});
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_mask();
    logic m;
    for (int i = 0; i < 7; i++) begin
      m = (i == FLG_MST_DONE);
      mmode <= m;
      wr(8'h08, 8'h00);
      pulse(i);
      chk("irq masked", 8'h00, {7'h00, irq});
      wr(8'h08, 8'h01 << i);
      repeat (2) @(posedge clk_i);
      chk("irq on", 8'h01, {7'h00, irq});
      if (i < 3 || i == FLG_MST_DONE) begin
        mmode <= !m;
        repeat (3) @(posedge clk_i);
        chk("irq mode", 8'h00, {7'h00, irq});
        mmode <= m;
      end
      if (i < 3) wr(8'h04, 8'h01 << i);
      else rd(8'h0C, 8'h00, "data");
      repeat (2) @(posedge clk_i);
      chk("irq clear", 8'h00, {7'h00, irq});
    end
    wr(8'h08, 8'hFF);
    rd(8'h08, 8'h7F, "mask rw");
    wr(8'h08, 8'h00);
  endtask
  task automatic t_data();
    wr(8'h0C, 8'hA5);
    rd(8'h0C, 8'hA5, "data rw");
    @(posedge clk_i);
    {rx_load, rx_byte} <= {1'b1, 8'h3C};
    @(posedge clk_i);
    rx_load <= 1'b0;
    @(posedge clk_i);
    chk("buffer", 8'h3C, buf_o);
    rd(8'h0C, 8'h3C, "data rx");
  endtask
  task automatic t_addr();
    wr(8'h10, 8'h42);
    wr(8'h14, 8'h5B);
    rd(8'h10, 8'h00, "prim wo");
    rd(8'h14, 8'h00, "sec wo");
    match(8'h43, 2'b10);
    match(8'h5A, 2'b01);
    match(8'h44, 2'b00);
    rd(8'h1C, 8'h00, "unmapped");
  endtask
  task automatic t_ovr();
    {det, busy} <= 2'b11;
    repeat (QC + 8) @(posedge clk_i);
    rd(8'h18, 8'hE3, "ovr idle");
    {hdl, det, busy} <= 3'b100;
    repeat (6) @(posedge clk_i);
    rd(8'h18, 8'h80, "ovr low");
    hdl <= 1'b0;
    wr(8'h18, 8'h1C);
    repeat (4) @(posedge clk_i);
    chk("oe_n on", 8'h00, {6'h00, cl_oe_n, dl_oe_n});
    rd(8'h18, 8'h18, "ovr forced");
    chk("aborts", 8'h01, 8'(aborts));
    wr(8'h18, 8'h00);
    repeat (2) @(posedge clk_i);
    chk("oe_n off", 8'h03, {6'h00, cl_oe_n, dl_oe_n});
    rd(8'h18, 8'hC0, "quiet early");
    repeat (QC + 8) @(posedge clk_i);
    rd(8'h18, 8'hE0, "quiet late");
    {ecl, edl} <= 2'b10;
    repeat (2) @(posedge clk_i);
    chk("oe_n engine clk", 8'h01, {6'h00, cl_oe_n, dl_oe_n});
    {ecl, edl} <= 2'b01;
    repeat (2) @(posedge clk_i);
    chk("oe_n engine data", 8'h02, {6'h00, cl_oe_n, dl_oe_n});
    {ecl, edl} <= 2'b00;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(8'h08, 8'h00, "mask rst");
    rd(8'h04, {1'b0, FLAGS_RST}, "status rst");
    t_mask();
    t_data();
    t_addr();
    t_ovr();
    conclude();
  end
  initial begin
    #400000;
    mismatches++;
    conclude();
  end
endmodule
`default_nettype wire
